// ---- dv/pe_model.sv ----
// processor element issuing memory-mapped register accesses
`timescale 1ns/10ps
module pe_model (
    // clock
    input  wire logic        clk,
    // request
    output logic             acc_valid,
    output logic             acc_write,
    output logic             acc_nonsecure,
    output logic [31:0]      acc_addr,
    output logic [31:0]      acc_wdata,
    // answer
    input  wire logic        rsp_valid,
    input  wire logic [31:0] rsp_rdata
);
    initial begin
        acc_valid = 1'b0;
        acc_write = 1'b0;
        acc_nonsecure = 1'b0;
        acc_addr = 32'h0;
        acc_wdata = 32'h0;
    end

    // one-cycle request, answer looked for after the taking edge
    task automatic access(input logic wr, input logic ns,
                          input logic [31:0] addr, input logic [31:0] wd,
                          output logic [31:0] rd, output logic got);
        int i;
        got = 1'b0;
        rd = 32'h0;
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_write <= wr;
        acc_nonsecure <= ns;
        acc_addr <= addr;
        acc_wdata <= wd;
        @(posedge clk);
        acc_valid <= 1'b0;
        // released lines do not keep the old value
        acc_addr <= ~addr;
        acc_wdata <= ~wd;
        for (i = 0; i < 4 && !got; i++) begin
            #1;
            if (rsp_valid === 1'b1) begin
                got = 1'b1;
                rd = rsp_rdata;
            end else begin
                @(posedge clk);
            end
        end
    endtask
endmodule

// ---- dv/prio_status_monitor.sv ----
// port checks of the running priority and status block
`timescale 1ns/10ps
module prio_status_monitor #(
    parameter bit          STATUS_IMPL = 1'b1,
    parameter bit          TWO_SEC     = 1'b1,
    parameter logic [31:0] PHYS_BASE   = 32'h0000_0000,
    parameter logic [31:0] VIRT_BASE   = 32'h0001_0000
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // access and answer
    input wire logic        acc_valid,
    input wire logic        acc_write,
    input wire logic        acc_nonsecure,
    input wire logic [31:0] acc_addr,
    input wire logic [31:0] acc_wdata,
    input wire logic        rsp_valid,
    input wire logic [31:0] rsp_rdata,
    // interrupt state and commands
    input wire logic        active_present,
    input wire logic [7:0]  active_prio,
    input wire logic [24:0] virt_ack_intid,
    input wire logic        virt_ack_pulse,
    input wire logic        virt_eoi_pulse,
    input wire logic        virt_deact_pulse,
    input wire logic [24:0] virt_cmd_intid
);
    logic [31:0] poff;
    logic [31:0] voff;
    logic [16:0] vw;
    logic        p_hit;
    logic        v_hit;
    logic        p_rp;
    logic [7:0]  rp;
    logic [7:0]  ns_rp;
    logic [24:0] wd25;
    assign poff  = acc_addr - PHYS_BASE;
    assign voff  = acc_addr - {VIRT_BASE[31:16], 16'h0000};
    assign vw    = voff[16:0] & 17'h1fffc;
    assign p_hit = acc_valid && (poff < cpu_if_pkg::FRAME_SPAN);
    assign v_hit = acc_valid && (voff < cpu_if_pkg::VIRT_SPAN);
    assign p_rp  = p_hit && !acc_write && (poff[12:0] & 13'h1ffc) == 13'h0014;
    assign rp    = active_present ? (active_prio & 8'hf8) : 8'hf8;
    assign ns_rp = (rp < 8'h80) ? 8'h00 : {rp[6:0], 1'b0};
    assign wd25  = acc_wdata[24:0];

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_answer_next: assert property ((p_hit || v_hit) |=> rsp_valid)
        else $error("access in a frame got no answer");
    a_no_stray: assert property (!(p_hit || v_hit) |=> !rsp_valid)
        else $error("answer without an access in a frame");
    a_rprio_secure: assert property (p_rp && !acc_nonsecure
        |=> rsp_rdata == {24'h0, $past(rp)})
        else $error("secure running priority wrong");
    a_rprio_nonsec: assert property (p_rp && acc_nonsecure && TWO_SEC
        |=> rsp_rdata == {24'h0, $past(ns_rp)})
        else $error("non-secure running priority wrong");
    a_eoi_command: assert property (v_hit && acc_write && vw == 17'h00010
        |=> virt_eoi_pulse && virt_cmd_intid == $past(wd25))
        else $error("end of interrupt command wrong");
    a_deact_alias: assert property (v_hit && acc_write
        && (vw == 17'h01000 || vw == 17'h10000) |=> virt_deact_pulse)
        else $error("deactivate command missing");
    a_ack_value: assert property (v_hit && !acc_write && vw == 17'h0000c
        |=> virt_ack_pulse && rsp_rdata == {7'h0, $past(virt_ack_intid)})
        else $error("acknowledge read wrong");
    a_apr2_zero: assert property (v_hit && !acc_write
        && vw >= 17'h000e0 && vw <= 17'h000ec |=> rsp_rdata == 32'h0)
        else $error("second priority range not zero");
    a_reserved_zero: assert property (v_hit && !acc_write
        && vw >= 17'h00100 && vw < 17'h01000 |=> rsp_rdata == 32'h0)
        else $error("reserved virtual read not zero");

    c_ns_phys: cover property (p_hit && acc_nonsecure);
    c_deact: cover property (virt_deact_pulse);
    c_virt_write: cover property (v_hit && acc_write);
endmodule

bind cpu_if_running_prio_status prio_status_monitor #(
    .STATUS_IMPL(STATUS_IMPL), .TWO_SEC(TWO_SEC),
    .PHYS_BASE(PHYS_BASE), .VIRT_BASE(VIRT_BASE)
) mon (.clk(clk), .reset_n(reset_n), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_nonsecure(acc_nonsecure),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .active_present(active_present),
    .active_prio(active_prio), .virt_ack_intid(virt_ack_intid),
    .virt_ack_pulse(virt_ack_pulse), .virt_eoi_pulse(virt_eoi_pulse),
    .virt_deact_pulse(virt_deact_pulse), .virt_cmd_intid(virt_cmd_intid));

// ---- dv/testbench.sv ----
// self-checking bench of the running priority and status block
`timescale 1ns/10ps
module testbench;
    localparam logic [31:0] VB = 32'h0001_0000;
    logic        clk;
    logic        reset_n;
    logic        sysreg_enable;
    logic        act_p;
    logic [7:0]  act_v;
    logic        vact_p;
    logic [7:0]  vact_v;
    logic [24:0] ids [4];
    logic        acc_valid;
    logic        acc_write;
    logic        acc_ns;
    logic [31:0] acc_addr;
    logic [31:0] acc_wdata;
    logic        rsp_valid;
    logic [31:0] rsp_rdata;
    logic        ack_p;
    logic        aack_p;
    logic        eoi_p;
    logic        aeoi_p;
    logic        deact_p;
    logic [24:0] cmd_id;
    logic [7:0]  pmask;
    logic [31:0] vctl;
    logic [2:0]  vbp;
    logic [2:0]  vabp;
    logic [31:0] rd;
    logic        got;
    int          fails;
    int          total_checks;
    logic [7:0]  tv [5] = '{8'h00, 8'h47, 8'hc5, 8'h00, 8'h47};
    logic [7:0]  te [5] = '{8'hf8, 8'h40, 8'h80, 8'hf0, 8'h00};
    logic [31:0] ra [4] = '{32'hc, 32'h20, 32'h18, 32'h28};

    cpu_if_running_prio_status uut (.clk(clk), .reset_n(reset_n),
        .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_nonsecure(acc_ns), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .sysreg_enable(sysreg_enable),
        .active_present(act_p), .active_prio(act_v),
        .virt_active_present(vact_p), .virt_active_prio(vact_v),
        .virt_ack_intid(ids[0]), .virt_alias_ack_intid(ids[1]),
        .virt_hpend_intid(ids[2]), .virt_alias_hpend_intid(ids[3]),
        .virt_ack_pulse(ack_p), .virt_alias_ack_pulse(aack_p),
        .virt_eoi_pulse(eoi_p), .virt_alias_eoi_pulse(aeoi_p),
        .virt_deact_pulse(deact_p), .virt_cmd_intid(cmd_id),
        .virt_control(vctl), .virt_prio_mask(pmask), .virt_bin_point(vbp),
        .virt_alias_bin_point(vabp));

    pe_model pe (.clk(clk), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_nonsecure(acc_ns), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk32(string nm, logic [31:0] exp, logic [31:0] seen);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic chk1(string nm, logic exp, logic seen);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", nm, exp, seen);
        end
    endtask

    task automatic rdc(logic ns, logic [31:0] a, logic [31:0] e, string nm);
        pe.access(1'b0, ns, a, 32'h0, rd, got);
        chk1("answer", 1'b1, got);
        chk32(nm, e, rd);
    endtask

    task automatic wr(logic ns, logic [31:0] a, logic [31:0] d);
        pe.access(1'b1, ns, a, d, rd, got);
        chk1("answer", 1'b1, got);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        reset_n = 1'b0;
        sysreg_enable = 1'b0;
        act_p = 1'b0;
        act_v = 8'h00;
        vact_p = 1'b1;
        vact_v = 8'h9b;
        ids = '{25'h1abcdef, 25'h0000123, 25'h0fedcba, 25'h1000007};
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk32("prio mask reset", 32'h0, {24'h0, pmask});
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            act_p <= 1'(5'b10110 >> i);
            act_v <= tv[i];
            rdc(1'(5'b11100 >> i), 32'h14, {24'h0, te[i]}, "rprio");
        end
        rdc(1'b0, VB + 32'h14, 32'h98, "virt rprio");
        $display("test running priority done");
        rdc(1'b0, VB + 32'h30, 32'h0, "reserved read");
        wr(1'b0, VB + 32'h30, 32'hffff_ffff);
        rdc(1'b0, VB + 32'h10, 32'h0, "wo read");
        wr(1'b0, VB + 32'hc, 32'h1);
        rdc(1'b0, VB + 32'h2c, 32'h0f, "virt status");
        wr(1'b0, VB + 32'h2c, 32'h05);
        rdc(1'b0, VB + 32'h2c, 32'h0a, "virt partial clr");
        wr(1'b0, VB + 32'h2c, 32'h0a);
        rdc(1'b0, VB + 32'h2c, 32'h0, "virt clr");
        $display("test virtual status done");
        rdc(1'b1, 32'h20, 32'h0, "secure only read");
        wr(1'b1, 32'h14, 32'h0);
        rdc(1'b1, 32'h2c, 32'h18, "ns status");
        rdc(1'b0, 32'h2c, 32'h0, "s status");
        @(posedge clk);
        sysreg_enable <= 1'b1;
        wr(1'b1, 32'h2c, 32'h1f);
        rdc(1'b1, 32'h30, 32'h0, "res read frozen");
        rdc(1'b1, 32'h2c, 32'h18, "frozen status");
        @(posedge clk);
        sysreg_enable <= 1'b0;
        wr(1'b1, 32'h2c, 32'h18);
        rdc(1'b1, 32'h2c, 32'h0, "ns clr");
        $display("test physical status done");
        wr(1'b0, VB + 32'h10, 32'h0123_4567);
        chk1("eoi pulse", 1'b1, eoi_p);
        chk32("cmd intid", 32'h0123_4567, {7'h0, cmd_id});
        wr(1'b0, VB + 32'h24, 32'h42);
        chk1("alias eoi pulse", 1'b1, aeoi_p);
        for (int i = 0; i < 2; i++) begin
            wr(1'b0, VB + (i ? 32'h1_0000 : 32'h1000), 32'h7);
            chk1("deact pulse", 1'b1, deact_p);
        end
        for (int i = 0; i < 4; i++) begin
            rdc(1'b0, VB + ra[i], {7'h0, ids[i]}, "id read");
            chk1("ack pulse", i == 0, ack_p);
            chk1("alias ack pulse", i == 1, aack_p);
        end
        $display("test virtual commands done");
        wr(1'b0, VB + 32'hd0, 32'h5a);
        rdc(1'b0, VB + 32'hd0, 32'h5a, "apr");
        wr(1'b0, VB + 32'he0, 32'hff);
        rdc(1'b0, VB + 32'he0, 32'h0, "apr2");
        wr(1'b0, VB + 32'h4, 32'hff);
        chk32("prio mask", 32'hf8, {24'h0, pmask});
        wr(1'b0, VB + 32'h0, 32'h0000_0201);
        chk32("virt control", 32'h0000_0201, vctl);
        wr(1'b0, VB + 32'h8, 32'h5);
        chk32("bin point", 32'h5, {29'h0, vbp});
        wr(1'b0, VB + 32'h1c, 32'h3);
        chk32("alias bin point", 32'h3, {29'h0, vabp});
        rdc(1'b0, VB + 32'hfc, cpu_if_pkg::IDENT_VALUE, "ident");
        for (int i = 0; i < 2; i++) begin
            pe.access(1'b0, 1'b0, i ? 32'h3_0000 : 32'h8000, 0, rd, got);
            chk1("stray answer", 1'b0, got);
        end
        $display("test virtual map done");
        summarize();
    end
endmodule

// ---- src/cpu_if_pkg.sv ----
// constants, access kinds and decode functions of the processor interface
package cpu_if_pkg;

    // frame geometry
    localparam logic [31:0] FRAME_SPAN   = 32'h0000_2000;
    localparam logic [31:0] VIRT_SPAN    = 32'h0002_0000;
    localparam logic [31:0] ALIAS_START  = 32'h0000_f000;
    localparam logic [31:0] ALIAS_END    = 32'h0001_1000;
    localparam logic [15:0] PAGE_ZERO    = 16'h0000;

    // register offsets within a frame
    localparam logic [12:0] OFF_CTRL     = 13'h0000;
    localparam logic [12:0] OFF_PMASK    = 13'h0004;
    localparam logic [12:0] OFF_BPOINT   = 13'h0008;
    localparam logic [12:0] OFF_ACK      = 13'h000c;
    localparam logic [12:0] OFF_EOI      = 13'h0010;
    localparam logic [12:0] OFF_RPRIO    = 13'h0014;
    localparam logic [12:0] OFF_HPEND    = 13'h0018;
    localparam logic [12:0] OFF_ABPOINT  = 13'h001c;
    localparam logic [12:0] OFF_AACK     = 13'h0020;
    localparam logic [12:0] OFF_AEOI     = 13'h0024;
    localparam logic [12:0] OFF_AHPEND   = 13'h0028;
    localparam logic [12:0] OFF_STATUS   = 13'h002c;
    localparam logic [12:0] OFF_RES0_LO  = 13'h0030;
    localparam logic [12:0] OFF_IMPL_LO  = 13'h0040;
    localparam logic [12:0] OFF_APR_LO   = 13'h00d0;
    localparam logic [12:0] OFF_APR2_LO  = 13'h00e0;
    localparam logic [12:0] OFF_RES1_LO  = 13'h00f0;
    localparam logic [12:0] OFF_IDENT    = 13'h00fc;
    localparam logic [12:0] OFF_RES2_LO  = 13'h0100;
    localparam logic [12:0] OFF_DEACT    = 13'h1000;
    localparam int          APR_COUNT    = 4;
    localparam int          APR_IDX_LSB  = 2;

    // status flag positions
    localparam int STS_W   = 5;
    localparam int STS_RRD = 0;
    localparam int STS_WRD = 1;
    localparam int STS_RWO = 2;
    localparam int STS_WRO = 3;
    localparam int STS_SEC = 4;

    // priority handling: five implemented priority bits
    localparam logic [7:0] PRIO_IMPL_MASK = 8'hf8;
    localparam logic [7:0] IDLE_PRIO      = 8'hf8;
    localparam logic [7:0] GROUP_MIN_MASK = 8'hfe;
    localparam logic [7:0] NS_THRESH      = 8'h80;
    localparam logic [7:0] PRIO_ZERO      = 8'h00;

    // field widths
    localparam int INTID_W  = 25;
    localparam int BPOINT_W = 3;

    // identification value, arbitrary
    localparam logic [31:0] IDENT_VALUE = 32'h0001_0a5c;

    typedef enum logic [2:0] {
        ACC_RW    = 3'b000,
        ACC_RO    = 3'b001,
        ACC_WO    = 3'b010,
        ACC_RAZWI = 3'b011,
        ACC_RES   = 3'b100
    } acc_kind_t;

    // access type of a word offset inside a frame
    function automatic acc_kind_t classify(input logic [12:0] off,
                                           input logic        virt,
                                           input logic        sts_impl);
        logic [12:0] w;
        w = {off[12:2], 2'b00};
        if (w >= OFF_DEACT)
            classify = (w == OFF_DEACT) ? ACC_WO : ACC_RES;
        else if (w >= OFF_RES2_LO)
            classify = ACC_RES;
        else if (w == OFF_IDENT)
            classify = ACC_RO;
        else if (w >= OFF_RES1_LO)
            classify = ACC_RES;
        else if (w >= OFF_APR2_LO)
            classify = virt ? ACC_RAZWI : ACC_RW;
        else if (w >= OFF_APR_LO)
            classify = ACC_RW;
        else if (w >= OFF_IMPL_LO)
            classify = ACC_RAZWI;
        else if (w >= OFF_RES0_LO)
            classify = ACC_RES;
        else if (w == OFF_STATUS)
            classify = sts_impl ? ACC_RW : ACC_RAZWI;
        else if (w == OFF_EOI || w == OFF_AEOI)
            classify = ACC_WO;
        else if (w == OFF_ACK || w == OFF_RPRIO || w == OFF_HPEND ||
                 w == OFF_AACK || w == OFF_AHPEND)
            classify = ACC_RO;
        else
            classify = ACC_RW;
    endfunction

    // physical registers reachable by secure accesses only
    function automatic logic secure_only(input logic [12:0] off);
        logic [12:0] w;
        w = {off[12:2], 2'b00};
        secure_only = (w >= OFF_ABPOINT) && (w <= OFF_AHPEND);
    endfunction

    // group priority as if the binary point were at its minimum
    function automatic logic [7:0] group_prio(input logic       present,
                                              input logic [7:0] prio);
        group_prio = present ? (prio & GROUP_MIN_MASK & PRIO_IMPL_MASK)
                             : IDLE_PRIO;
    endfunction

endpackage

// ---- src/cpu_if_running_prio_status.sv ----
// running priority, access violation status and virtual frame decode
`timescale 1ns/10ps
module cpu_if_running_prio_status #(
    parameter bit          STATUS_IMPL = 1'b1,
    parameter bit          TWO_SEC     = 1'b1,
    parameter logic [31:0] PHYS_BASE   = 32'h0000_0000,
    parameter logic [31:0] VIRT_BASE   = 32'h0001_0000
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // memory-mapped access
    input  wire logic        acc_valid,
    input  wire logic        acc_write,
    input  wire logic        acc_nonsecure,
    input  wire logic [31:0] acc_addr,
    input  wire logic [31:0] acc_wdata,
    // access answer
    output logic             rsp_valid,
    output logic [31:0]      rsp_rdata,
    // interrupt state from the priority core and list registers
    input  wire logic        sysreg_enable,
    input  wire logic        active_present,
    input  wire logic [7:0]  active_prio,
    input  wire logic        virt_active_present,
    input  wire logic [7:0]  virt_active_prio,
    input  wire logic [24:0] virt_ack_intid,
    input  wire logic [24:0] virt_alias_ack_intid,
    input  wire logic [24:0] virt_hpend_intid,
    input  wire logic [24:0] virt_alias_hpend_intid,
    // virtual commands toward the list registers
    output logic             virt_ack_pulse,
    output logic             virt_alias_ack_pulse,
    output logic             virt_eoi_pulse,
    output logic             virt_alias_eoi_pulse,
    output logic             virt_deact_pulse,
    output logic [24:0]      virt_cmd_intid,
    // virtual settings
    output logic [31:0]      virt_control,
    output logic [7:0]       virt_prio_mask,
    output logic [2:0]       virt_bin_point,
    output logic [2:0]       virt_alias_bin_point
);

    // reset release
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // frame decode
    logic [31:0]             prel;
    logic [31:0]             vrel;
    logic                    phys_hit;
    logic                    virt_hit;
    logic                    virt_in;
    logic [31:0]             voff;
    logic [12:0]             off;
    logic [12:0]             woff;
    cpu_if_pkg::acc_kind_t   kind;
    logic                    sec_block;
    logic                    rd;
    logic                    wr;

    assign prel = acc_addr - PHYS_BASE;
    assign vrel = acc_addr - {VIRT_BASE[31:16], cpu_if_pkg::PAGE_ZERO};
    assign phys_hit = prel < cpu_if_pkg::FRAME_SPAN;
    assign virt_hit = !phys_hit && (vrel < cpu_if_pkg::VIRT_SPAN);

    always_comb begin
        virt_in = 1'b1;
        voff    = vrel;
        if (vrel >= cpu_if_pkg::ALIAS_START && vrel < cpu_if_pkg::ALIAS_END)
            voff = vrel - cpu_if_pkg::ALIAS_START;
        else if (vrel >= cpu_if_pkg::FRAME_SPAN)
            virt_in = 1'b0;
    end

    // same offset in both frames
    assign off  = phys_hit ? prel[12:0] : voff[12:0];
    assign woff = {off[12:2], 2'b00};

    always_comb begin
        if (virt_hit && !virt_in)
            kind = cpu_if_pkg::ACC_RES;
        else
            kind = cpu_if_pkg::classify(off, virt_hit, STATUS_IMPL);
    end

    assign sec_block = TWO_SEC && phys_hit && acc_nonsecure
                       && cpu_if_pkg::secure_only(off);
    assign rd = acc_valid && !acc_write && (phys_hit || virt_hit);
    assign wr = acc_valid && acc_write && (phys_hit || virt_hit);

    // violation detection
    logic [4:0] viol;
    logic       sts_upd;
    logic       ns_bank;

    always_comb begin
        viol = '0;
        viol[cpu_if_pkg::STS_RRD] = rd && kind == cpu_if_pkg::ACC_RES;
        viol[cpu_if_pkg::STS_WRD] = wr && kind == cpu_if_pkg::ACC_RES;
        viol[cpu_if_pkg::STS_RWO] = rd && kind == cpu_if_pkg::ACC_WO;
        viol[cpu_if_pkg::STS_WRO] = wr && kind == cpu_if_pkg::ACC_RO;
        viol[cpu_if_pkg::STS_SEC] = sec_block;
    end

    assign sts_upd = STATUS_IMPL && !sysreg_enable;
    assign ns_bank = TWO_SEC && acc_nonsecure;

    // status registers
    logic [4:0] sts_s_q;
    logic [4:0] sts_ns_q;
    logic [4:0] sts_v_q;
    logic       sts_wr;
    logic [4:0] set_p;
    logic [4:0] set_v;
    logic [4:0] clr_s;
    logic [4:0] clr_ns;
    logic [4:0] clr_v;

    assign sts_wr = wr && !sec_block && woff == cpu_if_pkg::OFF_STATUS;
    assign set_p  = (sts_upd && phys_hit) ? viol : '0;
    assign set_v  = (sts_upd && virt_hit) ? viol : '0;
    assign clr_s  = (sts_upd && sts_wr && phys_hit && !ns_bank)
                    ? acc_wdata[4:0] : '0;
    assign clr_ns = (sts_upd && sts_wr && phys_hit && ns_bank)
                    ? acc_wdata[4:0] : '0;
    assign clr_v  = (sts_upd && sts_wr && virt_hit)
                    ? acc_wdata[4:0] : '0;

    // set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sts_s_q  <= '0;
            sts_ns_q <= '0;
            sts_v_q  <= '0;
        end else begin
            sts_s_q  <= (sts_s_q & ~clr_s) | (ns_bank ? 5'h00 : set_p);
            sts_ns_q <= (sts_ns_q & ~clr_ns) | (ns_bank ? set_p : 5'h00);
            sts_v_q  <= (sts_v_q & ~clr_v) | set_v;
        end
    end

    // running priority views
    logic [7:0] rprio;
    logic [7:0] rprio_ns;
    logic [7:0] vprio;

    assign rprio = cpu_if_pkg::group_prio(active_present, active_prio);
    assign rprio_ns = (rprio < cpu_if_pkg::NS_THRESH) ? cpu_if_pkg::PRIO_ZERO
                      : {rprio[6:0], 1'b0};
    assign vprio = cpu_if_pkg::group_prio(virt_active_present,
                                          virt_active_prio);

    // virtual settings
    logic [31:0] vctrl_q;
    logic [7:0]  vpmask_q;
    logic [2:0]  vbp_q;
    logic [2:0]  vabp_q;
    logic [31:0] vapr_q [cpu_if_pkg::APR_COUNT];
    logic        vwr;

    assign vwr = wr && virt_hit && kind == cpu_if_pkg::ACC_RW;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            vctrl_q  <= '0;
            vpmask_q <= '0;
            vbp_q    <= '0;
            vabp_q   <= '0;
        end else if (vwr) begin
            if (woff == cpu_if_pkg::OFF_CTRL)
                vctrl_q <= acc_wdata;
            if (woff == cpu_if_pkg::OFF_PMASK)
                vpmask_q <= acc_wdata[7:0] & cpu_if_pkg::PRIO_IMPL_MASK;
            if (woff == cpu_if_pkg::OFF_BPOINT)
                vbp_q <= acc_wdata[2:0];
            if (woff == cpu_if_pkg::OFF_ABPOINT)
                vabp_q <= acc_wdata[2:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < cpu_if_pkg::APR_COUNT; gi++) begin : g_apr
            localparam logic [12:0] APR_OFF = cpu_if_pkg::OFF_APR_LO
                + 13'(gi << cpu_if_pkg::APR_IDX_LSB);
            always_ff @(posedge clk or negedge rst_n_q) begin
                if (!rst_n_q)
                    vapr_q[gi] <= '0;
                else if (vwr && woff == APR_OFF)
                    vapr_q[gi] <= acc_wdata;
            end
        end
    endgenerate

    // virtual command pulses
    logic        ack_q;
    logic        aack_q;
    logic        eoi_q;
    logic        aeoi_q;
    logic        deact_q;
    logic [24:0] cmd_id_q;
    logic        vrd_ok;
    logic        vwo_ok;

    assign vrd_ok = rd && virt_hit && kind == cpu_if_pkg::ACC_RO;
    assign vwo_ok = wr && virt_hit && kind == cpu_if_pkg::ACC_WO;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q   <= 1'b0;
            aack_q  <= 1'b0;
            eoi_q   <= 1'b0;
            aeoi_q  <= 1'b0;
            deact_q <= 1'b0;
        end else begin
            ack_q   <= vrd_ok && woff == cpu_if_pkg::OFF_ACK;
            aack_q  <= vrd_ok && woff == cpu_if_pkg::OFF_AACK;
            eoi_q   <= vwo_ok && woff == cpu_if_pkg::OFF_EOI;
            aeoi_q  <= vwo_ok && woff == cpu_if_pkg::OFF_AEOI;
            deact_q <= vwo_ok && woff == cpu_if_pkg::OFF_DEACT;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q)
            cmd_id_q <= '0;
        else if (vrd_ok && woff == cpu_if_pkg::OFF_ACK)
            cmd_id_q <= virt_ack_intid;
        else if (vrd_ok && woff == cpu_if_pkg::OFF_AACK)
            cmd_id_q <= virt_alias_ack_intid;
        else if (vwo_ok)
            cmd_id_q <= acc_wdata[cpu_if_pkg::INTID_W-1:0];
    end

    // read data
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = '0;
        if (rd && !sec_block && (kind == cpu_if_pkg::ACC_RW ||
                                 kind == cpu_if_pkg::ACC_RO)) begin
            if (phys_hit) begin
                case (woff)
                    cpu_if_pkg::OFF_RPRIO: begin
                        rdata_d[7:0] = ns_bank ? rprio_ns : rprio;
                    end
                    cpu_if_pkg::OFF_STATUS: begin
                        rdata_d[4:0] = ns_bank ? sts_ns_q : sts_s_q;
                    end
                    default: begin
                        rdata_d = '0;
                    end
                endcase
            end else begin
                case (woff)
                    cpu_if_pkg::OFF_CTRL:    rdata_d = vctrl_q;
                    cpu_if_pkg::OFF_PMASK:   rdata_d[7:0] = vpmask_q;
                    cpu_if_pkg::OFF_BPOINT:  rdata_d[2:0] = vbp_q;
                    cpu_if_pkg::OFF_ABPOINT: rdata_d[2:0] = vabp_q;
                    cpu_if_pkg::OFF_ACK: begin
                        rdata_d[24:0] = virt_ack_intid;
                    end
                    cpu_if_pkg::OFF_AACK: begin
                        rdata_d[24:0] = virt_alias_ack_intid;
                    end
                    cpu_if_pkg::OFF_HPEND: begin
                        rdata_d[24:0] = virt_hpend_intid;
                    end
                    cpu_if_pkg::OFF_AHPEND: begin
                        rdata_d[24:0] = virt_alias_hpend_intid;
                    end
                    cpu_if_pkg::OFF_RPRIO:   rdata_d[7:0] = vprio;
                    cpu_if_pkg::OFF_STATUS:  rdata_d[4:0] = sts_v_q;
                    cpu_if_pkg::OFF_IDENT:   rdata_d = cpu_if_pkg::IDENT_VALUE;
                    default: begin
                        if (woff >= cpu_if_pkg::OFF_APR_LO &&
                            woff < cpu_if_pkg::OFF_APR2_LO)
                            rdata_d = vapr_q[woff[3:2]];
                        else
                            rdata_d = '0;
                    end
                endcase
            end
        end
    end

    // answer one cycle after every access in either frame
    logic        rsp_valid_q;
    logic [31:0] rsp_rdata_q;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= '0;
        end else begin
            rsp_valid_q <= rd || wr;
            rsp_rdata_q <= rdata_d;
        end
    end

    assign rsp_valid            = rsp_valid_q;
    assign rsp_rdata            = rsp_rdata_q;
    assign virt_ack_pulse       = ack_q;
    assign virt_alias_ack_pulse = aack_q;
    assign virt_eoi_pulse       = eoi_q;
    assign virt_alias_eoi_pulse = aeoi_q;
    assign virt_deact_pulse     = deact_q;
    assign virt_cmd_intid       = cmd_id_q;
    assign virt_control         = vctrl_q;
    assign virt_prio_mask       = vpmask_q;
    assign virt_bin_point       = vbp_q;
    assign virt_alias_bin_point = vabp_q;

endmodule
